// file: erbp_asserts.sv
module erbp_checker (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_waitrequest,
	input wire logic [2:0]  ext_reg_select,
	input wire logic        transfer_strobe_n,
	input wire logic        rd_not_wr,
	input wire logic [15:0] shared_data_lines_out,
	input wire logic [15:0] shared_data_lines_oe,
	input wire logic [7:0]  port_c_lines_in
);
	// ==================================================
	// Bus checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_sel_match: assert property ($fell(transfer_strobe_n) |-> ext_reg_select == avs_address[4:2])
		else $error("select differs from slot");
	a_slot_range: assert property ($fell(transfer_strobe_n) |-> avs_address inside {[8'h40:8'h58]})
		else $error("strobe for internal address");
	a_never_rsvd: assert property (!transfer_strobe_n |-> ext_reg_select != 3'h7)
		else $error("strobe on reserved slot");
	a_access_hold: assert property (!transfer_strobe_n |-> $stable(ext_reg_select) && $stable(rd_not_wr))
		else $error("access changed under strobe");
	a_wr_drive: assert property (!transfer_strobe_n && !rd_not_wr |-> shared_data_lines_oe == 16'hFFFF)
		else $error("write data not driven");
	a_rd_float: assert property (!transfer_strobe_n && rd_not_wr |-> shared_data_lines_oe == 16'h0000)
		else $error("data driven during read");
	a_wr_steady: assert property (!transfer_strobe_n && !rd_not_wr |=> $stable(shared_data_lines_out))
		else $error("write data moved");
	a_wait_extends: assert property (!transfer_strobe_n && !port_c_lines_in[4] |=> !transfer_strobe_n)
		else $error("strobe ended during wait");
	a_strobe_answer: assert property ($rose(transfer_strobe_n) |-> !avs_waitrequest)
		else $error("no answer at strobe end");
	c_ext_write: cover property ($fell(transfer_strobe_n) && !rd_not_wr);
	c_ext_read: cover property ($fell(transfer_strobe_n) && rd_not_wr);
	c_stall: cover property (!transfer_strobe_n && !port_c_lines_in[4]);
endmodule

bind erbp_top erbp_checker u_erbp_checker (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
	.avs_waitrequest(avs_waitrequest), .ext_reg_select(ext_reg_select), .transfer_strobe_n(transfer_strobe_n),
	.rd_not_wr(rd_not_wr), .shared_data_lines_out(shared_data_lines_out),
	.shared_data_lines_oe(shared_data_lines_oe), .port_c_lines_in(port_c_lines_in));

// file: erbp_periph.sv
module erbp_periph (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [2:0]  ext_reg_select,
	input  wire logic        transfer_strobe_n,
	input  wire logic        rd_not_wr,
	input  wire logic [15:0] shared_data_lines_out,
	input  wire logic [3:0]  stall,
	output logic      [15:0] rd_data,
	output logic             wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// Slot storage and stall counter
	logic [15:0] mem [0:6];
	logic [15:0] last;
	logic [3:0]  cnt;
	logic        drive;
	assign drive = !transfer_strobe_n && rd_not_wr;
	assign rd_data = drive ? mem[ext_reg_select] : ~last;
	assign wait_n = transfer_strobe_n || cnt >= stall;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			last <= 16'h0000;
		end else begin
			if (!transfer_strobe_n && !rd_not_wr)
				mem[ext_reg_select] <= shared_data_lines_out;
			cnt <= transfer_strobe_n ? 4'h0 : (wait_n ? cnt : cnt + 4'h1);
			if (drive)
				last <= mem[ext_reg_select];
		end
	end
endmodule

// file: erbp_pin_mux.sv
module erbp_pin_mux #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] gp_en,
	input  wire logic [W-1:0] gp_out,
	input  wire logic [W-1:0] gp_dir,
	input  wire logic         od,
	input  wire logic [W-1:0] alt_en,
	input  wire logic [W-1:0] alt_out,
	input  wire logic [W-1:0] alt_oe,
	output logic      [W-1:0] pin_out,
	output logic      [W-1:0] pin_oe
);

	logic [W-1:0] next_out;
	logic [W-1:0] next_oe;

	// ==================================================
	// Pin function select
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (alt_en[i]) begin
				next_out[i] = alt_out[i];
				next_oe[i]  = alt_oe[i];
			end else if (gp_en[i] && od) begin
				next_out[i] = 1'b0;
				next_oe[i]  = gp_dir[i] & ~gp_out[i];
			end else if (gp_en[i]) begin
				next_out[i] = gp_out[i];
				next_oe[i]  = gp_dir[i];
			end else begin
				next_out[i] = 1'b0;
				next_oe[i]  = 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else if (ce) begin
			pin_out <= next_out;
			pin_oe  <= next_oe;
		end
	end

endmodule

// file: erbp_pkg.sv
package erbp_pkg;

	// ==================================================
	// Widths
	localparam int DATA_W    = 16;
	localparam int SEL_W     = 3;
	localparam int PB_W      = 8;
	localparam int PC_ALT_W  = 7;
	localparam int PD_W      = 4;
	localparam int WCNT_W    = 8;

	// ==================================================
	// Register byte offsets
	localparam logic [7:0] OFS_WAIT_CFG = 8'h00;
	localparam logic [7:0] OFS_PORT_CFG = 8'h04;
	localparam logic [7:0] OFS_PA_OUT   = 8'h08;
	localparam logic [7:0] OFS_PA_DIR   = 8'h0C;
	localparam logic [7:0] OFS_PA_IN    = 8'h10;
	localparam logic [7:0] OFS_PB_OUT   = 8'h14;
	localparam logic [7:0] OFS_PB_DIR   = 8'h18;
	localparam logic [7:0] OFS_PB_FUNC  = 8'h1C;
	localparam logic [7:0] OFS_PB_IN    = 8'h20;
	localparam logic [7:0] OFS_PC_OUT   = 8'h24;
	localparam logic [7:0] OFS_PC_DIR   = 8'h28;
	localparam logic [7:0] OFS_PC_FUNC  = 8'h2C;
	localparam logic [7:0] OFS_PC_IN    = 8'h30;
	localparam logic [7:0] OFS_PD       = 8'h34;
	localparam logic [7:0] OFS_STATUS   = 8'h38;
	localparam logic [7:0] OFS_EXT_BASE = 8'h40;
	localparam logic [7:0] OFS_EXT_RSVD = 8'h5C;

	// ==================================================
	// Field positions
	localparam int CFG_PA_EN_BIT  = 0;
	localparam int CFG_OD_BIT     = 1;
	localparam int CFG_REMAP_BIT  = 2;
	localparam int PC_WAIT_BIT    = 4;
	localparam int PD_IN_LSB      = 0;
	localparam int PD_OUT_LSB     = 4;

	// ==================================================
	// Reset values
	localparam logic [6:0]        RST_WAIT_CFG = 7'h00;
	localparam logic [2:0]        RST_PORT_CFG = 3'h0;
	localparam logic [DATA_W-1:0] RST_DATA16   = 16'h0000;
	localparam logic [PB_W-1:0]   RST_DATA8    = 8'h00;
	localparam logic [SEL_W-1:0]  RESERVED_SLOT = 3'h7;

	// ==================================================
	// Bus sequencer states
	typedef enum logic [2:0] {
		ERBP_IDLE,
		ERBP_SETUP,
		ERBP_STROBE,
		ERBP_WAITST,
		ERBP_ACK
	} erbp_state_t;

endpackage

// file: erbp_top.sv
// Local design decisions: the address map and register access over Avalon-MM.
module erbp_top (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [2:0]  ext_reg_select,
	output logic             transfer_strobe_n,
	output logic             rd_not_wr,
	input  wire logic [15:0] shared_data_lines_in,
	output logic      [15:0] shared_data_lines_out,
	output logic      [15:0] shared_data_lines_oe,
	input  wire logic [7:0]  port_b_lines_in,
	output logic      [7:0]  port_b_lines_out,
	output logic      [7:0]  port_b_lines_oe,
	input  wire logic [7:0]  port_b_alt_out,
	input  wire logic [7:0]  port_b_alt_oe,
	input  wire logic [7:0]  port_c_lines_in,
	output logic      [7:0]  port_c_lines_out,
	output logic      [7:0]  port_c_lines_oe,
	input  wire logic [6:0]  port_c_alt_out,
	input  wire logic [6:0]  port_c_alt_oe,
	output logic      [3:0]  port_d_outputs,
	input  wire logic [3:0]  port_d_inputs
);

	// ==================================================
	// Registers and state
	erbp_pkg::erbp_state_t     state;
	logic [6:0]                wait_cfg;
	logic [2:0]                port_cfg;
	logic [15:0]               pa_out;
	logic [15:0]               pa_dir;
	logic [7:0]                pb_out;
	logic [7:0]                pb_dir;
	logic [7:0]                pb_func;
	logic [7:0]                pc_out;
	logic [7:0]                pc_dir;
	logic [6:0]                pc_func;
	logic [7:0]                wait_count;
	logic                      req_write;
	logic                      req_ext;
	logic [7:0]                req_addr;
	logic                      ws_done;
	logic [15:0]               wdata_hold;
	logic [31:0]               next_readdata;
	logic                      req_valid;
	logic                      is_ext;
	logic                      wait_n;
	logic                      ext_drive;
	logic                      remap;
	logic [7:0]                pb_in_eff;
	logic [15:0]               pa_gp_out;
	logic [15:0]               pa_gp_dir;
	logic [15:0]               pa_gp_en;

	typedef erbp_pkg::erbp_state_t erbp_st_t;

	function automatic logic [15:0] erbp_merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		erbp_merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic erbp_is_ext_slot(input logic [7:0] a);
		erbp_is_ext_slot = (a >= erbp_pkg::OFS_EXT_BASE) && (a < erbp_pkg::OFS_EXT_RSVD);
	endfunction

	assign req_valid = avs_read | avs_write;
	assign is_ext    = erbp_is_ext_slot(avs_address);
	assign remap     = port_cfg[erbp_pkg::CFG_REMAP_BIT];
	assign wait_n    = pc_func[erbp_pkg::PC_WAIT_BIT] ? port_c_lines_in[erbp_pkg::PC_WAIT_BIT] : 1'b1;
	assign ext_drive = req_ext && req_write && (state != erbp_pkg::ERBP_IDLE)
		&& (state != erbp_pkg::ERBP_ACK);
	assign pb_in_eff = remap ? shared_data_lines_in[15:8] : port_b_lines_in;

	// ==================================================
	// Bus sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state   <= erbp_pkg::ERBP_IDLE;
			ws_done <= 1'b0;
		end else if (ce) begin
			case (state)
				erbp_pkg::ERBP_IDLE: begin
					ws_done <= 1'b0;
					if (req_valid && is_ext) begin
						state <= erbp_pkg::ERBP_SETUP;
					end else if (req_valid) begin
						state <= erbp_pkg::ERBP_ACK;
					end
				end
				erbp_pkg::ERBP_SETUP: begin
					state <= erbp_pkg::ERBP_STROBE;
				end
				erbp_pkg::ERBP_STROBE: begin
					if (wait_cfg[req_addr[4:2]] && !ws_done) begin
						state <= erbp_pkg::ERBP_WAITST;
					end else if (wait_n) begin
						state <= erbp_pkg::ERBP_ACK;
					end
				end
				erbp_pkg::ERBP_WAITST: begin
					ws_done <= 1'b1;
					state   <= erbp_pkg::ERBP_STROBE;
				end
				erbp_pkg::ERBP_ACK: begin
					state <= erbp_pkg::ERBP_IDLE;
				end
				default: begin
					state <= erbp_pkg::ERBP_IDLE;
				end
			endcase
		end
	end

	// ==================================================
	// Request capture
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_write  <= 1'b0;
			req_ext    <= 1'b0;
			req_addr   <= 8'h00;
			wdata_hold <= erbp_pkg::RST_DATA16;
		end else if (ce && state == erbp_pkg::ERBP_IDLE && req_valid) begin
			req_write  <= avs_write;
			req_ext    <= is_ext;
			req_addr   <= avs_address;
			wdata_hold <= avs_writedata[15:0];
		end
	end

	// ==================================================
	// External bus control pins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_reg_select    <= erbp_pkg::RESERVED_SLOT;
			transfer_strobe_n <= 1'b1;
			rd_not_wr         <= 1'b1;
		end else if (ce) begin
			if (state == erbp_pkg::ERBP_IDLE && req_valid) begin
				ext_reg_select <= avs_address[4:2];
				rd_not_wr      <= ~(avs_write && is_ext);
			end
			if (state == erbp_pkg::ERBP_SETUP) begin
				transfer_strobe_n <= 1'b0;
			end else if (state == erbp_pkg::ERBP_STROBE && wait_n
				&& !(wait_cfg[req_addr[4:2]] && !ws_done)) begin
				transfer_strobe_n <= 1'b1;
			end
			if (state == erbp_pkg::ERBP_ACK) begin
				rd_not_wr <= 1'b1;
			end
		end
	end

	// ==================================================
	// Wait cycle counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_count <= 8'h00;
		end else if (ce) begin
			if (state == erbp_pkg::ERBP_SETUP) begin
				wait_count <= 8'h00;
			end else if ((state == erbp_pkg::ERBP_WAITST || (state == erbp_pkg::ERBP_STROBE && !wait_n))
				&& wait_count != 8'hFF) begin
				wait_count <= wait_count + 8'h01;
			end
		end
	end

	// ==================================================
	// Read mux
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			erbp_pkg::OFS_WAIT_CFG: next_readdata[6:0]  = wait_cfg;
			erbp_pkg::OFS_PORT_CFG: next_readdata[2:0]  = port_cfg;
			erbp_pkg::OFS_PA_OUT:   next_readdata[15:0] = pa_out;
			erbp_pkg::OFS_PA_DIR:   next_readdata[15:0] = pa_dir;
			erbp_pkg::OFS_PA_IN:    next_readdata[15:0] = shared_data_lines_in;
			erbp_pkg::OFS_PB_OUT:   next_readdata[7:0]  = pb_out;
			erbp_pkg::OFS_PB_DIR:   next_readdata[7:0]  = pb_dir;
			erbp_pkg::OFS_PB_FUNC:  next_readdata[7:0]  = pb_func;
			erbp_pkg::OFS_PB_IN:    next_readdata[7:0]  = pb_in_eff;
			erbp_pkg::OFS_PC_OUT:   next_readdata[7:0]  = pc_out;
			erbp_pkg::OFS_PC_DIR:   next_readdata[7:0]  = pc_dir;
			erbp_pkg::OFS_PC_FUNC:  next_readdata[6:0]  = pc_func;
			erbp_pkg::OFS_PC_IN:    next_readdata[7:0]  = port_c_lines_in;
			erbp_pkg::OFS_PD:       next_readdata[7:0]  = {port_d_outputs, port_d_inputs};
			erbp_pkg::OFS_STATUS:   next_readdata[7:0]  = wait_count;
			default:                next_readdata = 32'h0000_0000;
		endcase
	end

	// ==================================================
	// Avalon answer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (ce) begin
			avs_waitrequest <= 1'b1;
			if (state == erbp_pkg::ERBP_IDLE && req_valid && !is_ext) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
			end else if (state == erbp_pkg::ERBP_STROBE && wait_n && !(wait_cfg[req_addr[4:2]] && !ws_done)) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= req_write ? 32'h0000_0000 : {16'h0000, shared_data_lines_in};
			end
		end
	end

	// ==================================================
	// Configuration registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_cfg <= erbp_pkg::RST_WAIT_CFG;
			port_cfg <= erbp_pkg::RST_PORT_CFG;
			pa_out   <= erbp_pkg::RST_DATA16;
			pa_dir   <= erbp_pkg::RST_DATA16;
			pb_out   <= erbp_pkg::RST_DATA8;
			pb_dir   <= erbp_pkg::RST_DATA8;
			pb_func  <= erbp_pkg::RST_DATA8;
			pc_out   <= erbp_pkg::RST_DATA8;
			pc_dir   <= erbp_pkg::RST_DATA8;
			pc_func  <= erbp_pkg::RST_WAIT_CFG;
			port_d_outputs <= 4'h0;
		end else if (ce && state == erbp_pkg::ERBP_ACK && req_write && !req_ext) begin
			case (req_addr)
				erbp_pkg::OFS_WAIT_CFG: if (avs_byteenable[0]) wait_cfg <= avs_writedata[6:0];
				erbp_pkg::OFS_PORT_CFG: if (avs_byteenable[0]) port_cfg <= avs_writedata[2:0];
				erbp_pkg::OFS_PA_OUT:   pa_out <= erbp_merge16(pa_out, avs_writedata, avs_byteenable);
				erbp_pkg::OFS_PA_DIR:   pa_dir <= erbp_merge16(pa_dir, avs_writedata, avs_byteenable);
				erbp_pkg::OFS_PB_OUT:   if (avs_byteenable[0]) pb_out <= avs_writedata[7:0];
				erbp_pkg::OFS_PB_DIR:   if (avs_byteenable[0]) pb_dir <= avs_writedata[7:0];
				erbp_pkg::OFS_PB_FUNC:  if (avs_byteenable[0]) pb_func <= avs_writedata[7:0];
				erbp_pkg::OFS_PC_OUT:   if (avs_byteenable[0]) pc_out <= avs_writedata[7:0];
				erbp_pkg::OFS_PC_DIR:   if (avs_byteenable[0]) pc_dir <= avs_writedata[7:0];
				erbp_pkg::OFS_PC_FUNC:  if (avs_byteenable[0]) pc_func <= avs_writedata[6:0];
				erbp_pkg::OFS_PD:       if (avs_byteenable[0]) port_d_outputs <= avs_writedata[7:4];
				default: begin
				end
			endcase
		end
	end

	// ==================================================
	// Pin drivers
	assign pa_gp_en  = {{8{port_cfg[erbp_pkg::CFG_PA_EN_BIT] | remap}}, {8{port_cfg[erbp_pkg::CFG_PA_EN_BIT]}}};
	assign pa_gp_out = {remap ? pb_out : pa_out[15:8], pa_out[7:0]};
	assign pa_gp_dir = {remap ? pb_dir : pa_dir[15:8], pa_dir[7:0]};

	erbp_pin_mux #(.W(16)) u_port_a (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.gp_en   (pa_gp_en),
		.gp_out  (pa_gp_out),
		.gp_dir  (pa_gp_dir),
		.od      (port_cfg[erbp_pkg::CFG_OD_BIT]),
		.alt_en  ({16{ext_drive}}),
		.alt_out (wdata_hold),
		.alt_oe  (16'hFFFF),
		.pin_out (shared_data_lines_out),
		.pin_oe  (shared_data_lines_oe)
	);

	erbp_pin_mux #(.W(8)) u_port_b (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.gp_en   ({8{~remap}}),
		.gp_out  (pb_out),
		.gp_dir  (pb_dir),
		.od      (1'b0),
		.alt_en  (pb_func & {8{~remap}}),
		.alt_out (port_b_alt_out),
		.alt_oe  (port_b_alt_oe),
		.pin_out (port_b_lines_out),
		.pin_oe  (port_b_lines_oe)
	);

	erbp_pin_mux #(.W(8)) u_port_c (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.gp_en   (8'hFF),
		.gp_out  (pc_out),
		.gp_dir  (pc_dir),
		.od      (1'b0),
		.alt_en  ({1'b0, pc_func}),
		.alt_out ({1'b0, port_c_alt_out[6:5], 1'b0, port_c_alt_out[3:0]}),
		.alt_oe  ({1'b0, port_c_alt_oe[6:5], 1'b0, port_c_alt_oe[3:0]}),
		.pin_out (port_c_lines_out),
		.pin_oe  (port_c_lines_oe)
	);

endmodule

// file: tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst_n, avs_read, avs_write, avs_waitrequest, transfer_strobe_n, rd_not_wr, wait_n;
	logic [7:0]  avs_address, port_b_lines_in, port_b_lines_out, port_b_lines_oe, port_b_alt_out, port_b_alt_oe;
	logic [7:0]  port_c_lines_out, port_c_lines_oe, pc_rand;
	logic [6:0]  port_c_alt_out, port_c_alt_oe;
	logic [31:0] avs_writedata, avs_readdata, seed, d;
	logic [15:0] sh_out, sh_oe, sh_in, pdata;
	logic [3:0]  port_d_outputs, port_d_inputs, stall;
	logic [2:0]  ext_reg_select;
	logic [63:0] expq [$];
	int          fail_count, n_checks, cyc;
	assign sh_in = (sh_oe & sh_out) | (~sh_oe & pdata);
	erbp_top u_erbp_top (.clock(clock), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_reg_select(ext_reg_select),
		.transfer_strobe_n(transfer_strobe_n), .rd_not_wr(rd_not_wr), .shared_data_lines_in(sh_in),
		.shared_data_lines_out(sh_out), .shared_data_lines_oe(sh_oe), .port_b_lines_in(port_b_lines_in),
		.port_b_lines_out(port_b_lines_out), .port_b_lines_oe(port_b_lines_oe),
		.port_b_alt_out(port_b_alt_out), .port_b_alt_oe(port_b_alt_oe),
		.port_c_lines_in({pc_rand[7:5], wait_n, pc_rand[3:0]}), .port_c_lines_out(port_c_lines_out),
		.port_c_lines_oe(port_c_lines_oe), .port_c_alt_out(port_c_alt_out), .port_c_alt_oe(port_c_alt_oe),
		.port_d_outputs(port_d_outputs), .port_d_inputs(port_d_inputs));
	erbp_periph u_erbp_periph (.clock(clock), .rst_n(rst_n), .ext_reg_select(ext_reg_select),
		.transfer_strobe_n(transfer_strobe_n), .rd_not_wr(rd_not_wr), .shared_data_lines_out(sh_out),
		.stall(stall), .rd_data(pdata), .wait_n(wait_n));
	// ==================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		if (n >= 200)
			chk("bus answer", 32'h0, 32'h1);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		expq.push_back({exp, mask});
		bus(1'b0, a, 32'h0);
	endtask
	// ==================================================
	// Read data monitor and timeout
	always @(posedge clock) begin
		logic [63:0] e;
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			e = expq.pop_front();
			chk("readdata", e[63:32], avs_readdata & e[31:0]);
		end
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			chk("timeout", 32'h0, 32'h1);
			final_report();
		end
	end
	always #20 clock = ~clock;
	// ==================================================
	// Main sequence
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{port_b_alt_out, port_b_alt_oe, port_c_alt_out, port_c_alt_oe, stall} = '0;
		seed = 32'h00013F7F;
		port_b_lines_in = seed[7:0];
		pc_rand = seed[15:8];
		port_d_inputs = seed[19:16];
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(8'h00, 32'h0, 32'hFFFFFFFF);
		rd(8'h04, 32'h0, 32'hFFFFFFFF);
		bus(1'b1, 8'h5C, 32'h1234);
		rd(8'h5C, 32'h0, 32'hFFFFFFFF);
		bus(1'b1, 8'h3C, 32'h5678);
		rd(8'h3C, 32'h0, 32'hFFFFFFFF);
		for (int s = 0; s < 7; s++) begin
			seed = lfsr(seed);
			bus(1'b1, 8'h40 + 8'(4 * s), seed);
			rd(8'h40 + 8'(4 * s), {16'h0, seed[15:0]}, 32'h0000FFFF);
		end
		bus(1'b1, 8'h2C, 32'h10);
		bus(1'b1, 8'h00, 32'h55);
		for (int s = 0; s < 7; s++) begin
			seed = lfsr(seed);
			stall <= (s % 2 == 0) ? 4'h0 : 4'(s % 3);
			bus(1'b1, 8'h40 + 8'(4 * s), seed);
			rd(8'h40 + 8'(4 * s), {16'h0, seed[15:0]}, 32'h0000FFFF);
			rd(8'h38, (s % 2 == 0) ? 32'h1 : 32'(s % 3), 32'h000000FF);
		end
		stall <= 4'h0;
		d = lfsr(seed);
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b1, 8'h0C, 32'h00FF);
		bus(1'b1, 8'h08, d);
		@(posedge clock);
		chk("port a oe", 32'h00FF, {16'h0, sh_oe});
		chk("port a out", {24'h0, d[7:0]}, {24'h0, sh_out[7:0]});
		bus(1'b1, 8'h04, 32'h3);
		@(posedge clock);
		chk("open drain oe", {24'h0, ~d[7:0]}, {16'h0, sh_oe});
		chk("open drain out", 32'h0, {16'h0, sh_out & sh_oe});
		bus(1'b1, 8'h04, 32'h4);
		bus(1'b1, 8'h18, 32'hFF);
		bus(1'b1, 8'h14, {24'h0, d[15:8]});
		@(posedge clock);
		chk("remap oe", 32'hFF, {24'h0, sh_oe[15:8]});
		chk("remap out", {24'h0, d[15:8]}, {24'h0, sh_out[15:8]});
		chk("port b oe off", 32'h0, {24'h0, port_b_lines_oe});
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h1C, 32'h0F);
		port_b_alt_out <= d[23:16];
		port_b_alt_oe <= 8'hFF;
		repeat (2) @(posedge clock);
		chk("port b out", {24'h0, d[15:12], d[19:16]}, {24'h0, port_b_lines_out});
		chk("port b oe", 32'hFF, {24'h0, port_b_lines_oe});
		port_c_alt_out <= d[30:24];
		port_c_alt_oe <= 7'h7F;
		bus(1'b1, 8'h28, 32'hFF);
		bus(1'b1, 8'h24, {24'h0, d[7:0]});
		bus(1'b1, 8'h2C, 32'h13);
		@(posedge clock);
		chk("port c oe", 32'hEF, {24'h0, port_c_lines_oe});
		chk("port c out", {24'h0, (d[7:0] & 8'hEC) | {6'h0, d[25:24]}}, {24'h0, port_c_lines_out & 8'hEF});
		bus(1'b1, 8'h34, {24'h0, d[7:0]});
		@(posedge clock);
		chk("port d out", {28'h0, d[7:4]}, {28'h0, port_d_outputs});
		rd(8'h34, {28'h0, port_d_inputs}, 32'h0000000F);
		rd(8'h20, {24'h0, port_b_lines_in}, 32'h000000FF);
		rd(8'h30, {24'h0, pc_rand[7:5], 1'b1, pc_rand[3:0]}, 32'h000000FF);
		final_report();
	end
endmodule
